// file: core/smsc_pkg.sv
// Purpose: shared constants and types for the stop-mode standby controller
// Assumes: 8-bit register bus, single 250 MHz always-on control clock
// Notes:   offsets, reset values and counts live here only
package smsc_pkg;

    // =====================================================================
    // register bus geometry
    localparam int unsigned ADDR_W = 3;
    localparam int unsigned DATA_W = 8;

    localparam logic [ADDR_W-1:0] OFS_STANDBY_CTRL = 3'h0;
    localparam logic [ADDR_W-1:0] OFS_STAB_TIME    = 3'h1;
    localparam logic [ADDR_W-1:0] OFS_IRQ_CFG      = 3'h2;
    localparam logic [ADDR_W-1:0] OFS_ANALOG_CTRL  = 3'h3;
    localparam logic [ADDR_W-1:0] OFS_STATUS       = 3'h4;

    // =====================================================================
    // field positions
    localparam int unsigned BIT_STOP_REQ   = 0;
    localparam int unsigned BIT_EXT_CLK    = 7;
    localparam int unsigned BIT_MASK_A     = 0;
    localparam int unsigned BIT_MSVC_A     = 1;
    localparam int unsigned BIT_MASK_B     = 2;
    localparam int unsigned BIT_MSVC_B     = 3;
    localparam int unsigned BIT_PRIO_SEL   = 4;
    localparam int unsigned BIT_ADC_ON     = 0;
    localparam int unsigned BIT_DAC_EN0    = 1;
    localparam int unsigned BIT_DAC_EN1    = 2;
    localparam int unsigned STAB_CODE_W    = 3;

    // =====================================================================
    // reset values
    localparam logic [DATA_W-1:0] RST_STANDBY_CTRL = 8'h00;
    localparam logic [DATA_W-1:0] RST_STAB_TIME    = 8'h07;
    localparam logic [DATA_W-1:0] RST_IRQ_CFG      = 8'h0f;
    localparam logic [DATA_W-1:0] RST_ANALOG_CTRL  = 8'h00;

    // =====================================================================
    // timing: stabilization time = base time shifted left by the code
    localparam int unsigned CLK_MHZ      = 250;
    localparam int unsigned STAB_BASE_NS = 64;
    localparam int unsigned STAB_BASE_CYC =
        (STAB_BASE_NS * CLK_MHZ + 999) / 1000;
    localparam int unsigned STAB_CNT_W   = 12;
    localparam int unsigned LEVEL_LOWEST = 3;

    // =====================================================================
    // controller states, gray along run -> stop -> stab -> wake
    typedef enum logic [1:0] {
        ST_RUN  = 2'b00,
        ST_STOP = 2'b01,
        ST_STAB = 2'b11,
        ST_WAKE = 2'b10
    } smsc_state_type;

    // pin and clock controls that travel together to the pad ring
    typedef struct packed {
        logic oscEnable;       // clock oscillator running
        logic sysClkEnable;    // internal system clock gate
        logic cpuRun;          // cpu and peripheral clocks
        logic ioHold;          // general i/o latched
        logic busPinOe;        // muxed_addr_data_pins, upper_addr_pins, strobes
        logic holdReqInEn;     // hold_request_in input buffer
        logic holdAckForceLow; // hold_ack_out forced low
        logic adcClkRun;       // a/d converter clock
    } smsc_pinctl_type;

    localparam smsc_pinctl_type PINCTL_RUN  = '{1'b1, 1'b1, 1'b1, 1'b0,
                                                 1'b1, 1'b1, 1'b0, 1'b1};
    localparam smsc_pinctl_type PINCTL_STOP = '{1'b0, 1'b0, 1'b0, 1'b1,
                                                 1'b0, 1'b0, 1'b1, 1'b0};
    localparam smsc_pinctl_type PINCTL_STAB = '{1'b1, 1'b0, 1'b0, 1'b1,
                                                 1'b0, 1'b0, 1'b1, 1'b0};

endpackage

// file: core/smsc_stab_timer.sv
// Purpose: oscillation stabilization timer for stop-mode wake-up
// Assumes: start is a one-cycle pulse, code is stable while counting
// Notes:   done pulses once, the count is base cycles shifted by code
`timescale 1ns/1ps
`default_nettype none
module smsc_stab_timer
(
    input  wire logic                              clk,
    input  wire logic                              rstn,
    input  wire logic                              ce,
    input  wire logic                              start,
    input  wire logic [smsc_pkg::STAB_CODE_W-1:0]  code,
    output logic                                   done
);

    // =====================================================================
    // count length
    localparam logic [smsc_pkg::STAB_CNT_W-1:0] BASE =
        smsc_pkg::STAB_CNT_W'(smsc_pkg::STAB_BASE_CYC);

    logic [smsc_pkg::STAB_CNT_W-1:0] cnt_r;
    logic                            busy_r;
    logic [smsc_pkg::STAB_CNT_W-1:0] loadVal;
    logic                            lastCyc;

    assign loadVal = (BASE << code) - smsc_pkg::STAB_CNT_W'(1);
    assign lastCyc = busy_r && (cnt_r == '0);

    // down counter, restarted by a fresh start pulse
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            cnt_r  <= '0;
            busy_r <= 1'b0;
            done   <= 1'b0;
        end
        else if (ce)
        begin
            done <= lastCyc;
            if (start)
            begin
                cnt_r  <= loadVal;
                busy_r <= 1'b1;
            end
            else if (lastCyc)
                busy_r <= 1'b0;
            else if (busy_r)
                cnt_r <= cnt_r - smsc_pkg::STAB_CNT_W'(1);
        end
    end

endmodule
`default_nettype wire

// file: core/smsc_standby_ctrl.sv
// Purpose: stop-mode standby control: entry, pin states, wake and pending
// Assumes: clk is the always-on control clock; wake pins are synchronous to it
// Notes:   the cpu's own clock is gated by pinCtl_r, not by this block
//
// Overview of operation
// - writing the stop bit as one requests oscillator-stopping standby
// - standby control register changes only on dedicated 8-bit writes and the stop bit self-clear
// - a release condition present at request aborts entry, cpu continues
// - stop halts oscillator, system clock, cpu, peripherals; ram retained
// - i/o held, bus pins floated, hold acknowledge low, refresh retained
// - a/d clock stops, d/a keeps running while enabled
// - cleared d/a channel enable floats that channel's analog output
// - only nmi pin, two external pins or reset end stop
// - nmi wake acknowledged when no equal or higher nmi handler runs
// - nmi wake under blocking handler resumes inline, request held pending
// - enabled pin wake acknowledged under lower or level-3 priority-select-clear handler
// - pin wake under same or higher handler, or interrupts disabled, resumes pending
// - masked or macro-service pin never releases stop
// - held requests are acknowledged as soon as that is possible
// - wake edge restarts oscillator; stop ends after stabilization time
// - reset in stop restarts oscillator, normal start, ram untouched
`timescale 1ns/1ps
`default_nettype none
module smsc_standby_ctrl
(
    input  wire logic                          clk,
    input  wire logic                          rstn,
    input  wire logic                          ce,
    input  wire logic [smsc_pkg::ADDR_W-1:0]   regAddr,
    input  wire logic [smsc_pkg::DATA_W-1:0]   regWdata,
    input  wire logic                          regWr,
    input  wire logic                          regRd,
    input  wire logic                          wrDedicated,
    input  wire logic                          instrDone,
    input  wire logic                          haltReleaseCond,
    input  wire logic                          nmiPin,
    input  wire logic                          extIrqPinA,
    input  wire logic                          extIrqPinB,
    input  wire logic [2:0]                    edgeRising,
    input  wire logic                          globalIrqEnable,
    input  wire logic                          nmiBlockSvc,
    input  wire logic                          maskSvcActive,
    input  wire logic [1:0]                    maskSvcLevel,
    input  wire logic [1:0]                    pinIrqLevel,
    output logic [smsc_pkg::DATA_W-1:0]        regRdata,
    output smsc_pkg::smsc_pinctl_type          pinCtl_r,
    output logic                               adcConvOn_r,
    output logic [1:0]                         dacAnalogOe_r,
    output logic                               extClkSelect_r,
    output logic                               resumeInline_r,
    output logic                               ackNmi_r,
    output logic                               ackPin_r
);

    // =====================================================================
    // registers and state
    logic [smsc_pkg::DATA_W-1:0] standbyCtrl_r;
    logic [smsc_pkg::DATA_W-1:0] stabTime_r;
    logic [smsc_pkg::DATA_W-1:0] irqCfg_r;
    logic [smsc_pkg::DATA_W-1:0] analogCtrl_r;
    smsc_pkg::smsc_state_type    state_r;
    smsc_pkg::smsc_state_type    state_nxt;
    logic [2:0]                  pinPrev_r;
    logic                        wakeByNmi_r;
    logic                        nmiPend_r;
    logic                        pinPend_r;
    logic                        stabDone;

    // =====================================================================
    // bus decode
    logic wrStandby;
    logic wrStab;
    logic wrIrq;
    logic wrAnalog;
    logic [smsc_pkg::DATA_W-1:0] rdMux;
    logic [smsc_pkg::DATA_W-1:0] statusWord;

    // the stop register ignores plain stores; only the dedicated path reaches it
    assign wrStandby = regWr && wrDedicated
                       && (regAddr == smsc_pkg::OFS_STANDBY_CTRL);
    assign wrStab    = regWr && (regAddr == smsc_pkg::OFS_STAB_TIME);
    assign wrIrq     = regWr && (regAddr == smsc_pkg::OFS_IRQ_CFG);
    assign wrAnalog  = regWr && (regAddr == smsc_pkg::OFS_ANALOG_CTRL);

    assign statusWord = {3'h0, nmiPend_r, pinPend_r, wakeByNmi_r, state_r};
    assign rdMux =
        (regAddr == smsc_pkg::OFS_STANDBY_CTRL) ? standbyCtrl_r :
        (regAddr == smsc_pkg::OFS_STAB_TIME)    ? stabTime_r    :
        (regAddr == smsc_pkg::OFS_IRQ_CFG)      ? irqCfg_r      :
        (regAddr == smsc_pkg::OFS_ANALOG_CTRL)  ? analogCtrl_r  :
        (regAddr == smsc_pkg::OFS_STATUS)       ? statusWord    : 8'h00;

    // =====================================================================
    // wake events: edge detect on the pins with programmable polarity
    function automatic logic edgeHit(input logic now, input logic prev, input logic rise);
        edgeHit = rise ? (now && !prev) : (!now && prev);
    endfunction

    logic nmiEdge;
    logic pinAEdge;
    logic pinBEdge;
    logic pinAArmed;
    logic pinBArmed;
    logic pinWake;
    logic wakeEvent;

    assign nmiEdge   = edgeHit(nmiPin, pinPrev_r[0], edgeRising[0]);
    assign pinAEdge  = edgeHit(extIrqPinA, pinPrev_r[1], edgeRising[1]);
    assign pinBEdge  = edgeHit(extIrqPinB, pinPrev_r[2], edgeRising[2]);
    // masked or macro-serviced pins cannot wake the part
    assign pinAArmed = !irqCfg_r[smsc_pkg::BIT_MASK_A] && !irqCfg_r[smsc_pkg::BIT_MSVC_A];
    assign pinBArmed = !irqCfg_r[smsc_pkg::BIT_MASK_B] && !irqCfg_r[smsc_pkg::BIT_MSVC_B];
    assign pinWake   = (pinAEdge && pinAArmed) || (pinBEdge && pinBArmed);
    assign wakeEvent = nmiEdge || pinWake;

    // =====================================================================
    // acknowledge decisions
    logic nmiAckOk;
    logic pinAckOk;
    logic prioSelClear;

    assign prioSelClear = !irqCfg_r[smsc_pkg::BIT_PRIO_SEL];
    assign nmiAckOk     = !nmiBlockSvc;
    // lower-priority handler means a larger level number than the pin's
    assign pinAckOk     = globalIrqEnable && !nmiBlockSvc
                       && (!maskSvcActive
                           || (pinIrqLevel < maskSvcLevel)
                           || (prioSelClear
                               && (maskSvcLevel == 2'(smsc_pkg::LEVEL_LOWEST))));

    // =====================================================================
    // entry conditions
    logic stopArmed;
    logic enterStop;
    logic abortStop;

    // entry waits for the writing instruction to retire
    assign stopArmed = standbyCtrl_r[smsc_pkg::BIT_STOP_REQ] && instrDone && state_r == smsc_pkg::ST_RUN;
    // a pending release source keeps the cpu running instead
    assign abortStop = stopArmed && (haltReleaseCond || nmiPend_r || pinPend_r);
    assign enterStop = stopArmed && !abortStop;

    // =====================================================================
    // next state
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            smsc_pkg::ST_RUN:
                if (enterStop)
                    state_nxt = smsc_pkg::ST_STOP;
            smsc_pkg::ST_STOP:
                if (wakeEvent)
                    state_nxt = smsc_pkg::ST_STAB;
            smsc_pkg::ST_STAB:
                if (stabDone)
                    state_nxt = smsc_pkg::ST_WAKE;
            smsc_pkg::ST_WAKE:
                state_nxt = smsc_pkg::ST_RUN;
            default:
                state_nxt = smsc_pkg::ST_RUN;
        endcase
    end

    logic timerStart;
    assign timerStart = (state_r == smsc_pkg::ST_STOP) && wakeEvent;

    smsc_stab_timer u_stab_timer
    (
        .clk   (clk),
        .rstn  (rstn),
        .ce    (ce),
        .start (timerStart),
        .code  (stabTime_r[smsc_pkg::STAB_CODE_W-1:0]),
        .done  (stabDone)
    );

    // =====================================================================
    // pad and clock controls per state
    smsc_pkg::smsc_pinctl_type pinCtlNxt;
    assign pinCtlNxt = (state_nxt == smsc_pkg::ST_STOP) ? smsc_pkg::PINCTL_STOP :
                       (state_nxt == smsc_pkg::ST_STAB) ? smsc_pkg::PINCTL_STAB :
                       smsc_pkg::PINCTL_RUN;

    // =====================================================================
    // wake outcome and pending requests
    logic inWake;
    logic nmiPendSet;
    logic pinPendSet;
    logic nmiPendAck;
    logic pinPendAck;

    assign inWake     = (state_r == smsc_pkg::ST_WAKE);
    assign nmiPendSet = inWake && wakeByNmi_r && !nmiAckOk;
    assign pinPendSet = inWake && !wakeByNmi_r && !pinAckOk;
    assign nmiPendAck = (state_r == smsc_pkg::ST_RUN) && nmiPend_r && nmiAckOk;
    assign pinPendAck = (state_r == smsc_pkg::ST_RUN) && pinPend_r && pinAckOk && !nmiPendAck;

    // software registers; the stop bit self-clears once the request is consumed
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            standbyCtrl_r <= smsc_pkg::RST_STANDBY_CTRL;
            stabTime_r    <= smsc_pkg::RST_STAB_TIME;
            irqCfg_r      <= smsc_pkg::RST_IRQ_CFG;
            analogCtrl_r  <= smsc_pkg::RST_ANALOG_CTRL;
        end
        else if (ce)
        begin
            if (wrStandby)
                standbyCtrl_r <= regWdata;
            else if (stopArmed)
                standbyCtrl_r[smsc_pkg::BIT_STOP_REQ] <= 1'b0;
            if (wrStab)
                stabTime_r <= regWdata;
            if (wrIrq)
                irqCfg_r <= regWdata;
            if (wrAnalog)
                analogCtrl_r <= regWdata;
        end
    end

    // state, pin history and wake source; reset puts the oscillator back on
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_r     <= smsc_pkg::ST_RUN;
            pinPrev_r   <= 3'h0;
            wakeByNmi_r <= 1'b0;
        end
        else if (ce)
        begin
            state_r   <= state_nxt;
            pinPrev_r <= {extIrqPinB, extIrqPinA, nmiPin};
            if (timerStart)
                wakeByNmi_r <= nmiEdge; // nmi wins when both arrive together
        end
    end

    // pending flags: a new hold wins over its own acknowledge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            nmiPend_r <= 1'b0;
            pinPend_r <= 1'b0;
        end
        else if (ce)
        begin
            nmiPend_r <= nmiPendSet || (nmiPend_r && !nmiPendAck);
            pinPend_r <= pinPendSet || (pinPend_r && !pinPendAck);
        end
    end

    // outputs, all registered
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            regRdata       <= 8'h00;
            pinCtl_r       <= smsc_pkg::PINCTL_RUN;
            adcConvOn_r    <= 1'b0;
            dacAnalogOe_r  <= 2'h0;
            extClkSelect_r <= 1'b0;
            resumeInline_r <= 1'b0;
            ackNmi_r       <= 1'b0;
            ackPin_r       <= 1'b0;
        end
        else if (ce)
        begin
            regRdata       <= regRd ? rdMux : 8'h00;
            pinCtl_r       <= pinCtlNxt;
            adcConvOn_r    <= analogCtrl_r[smsc_pkg::BIT_ADC_ON];
            dacAnalogOe_r  <= {analogCtrl_r[smsc_pkg::BIT_DAC_EN1],
                               analogCtrl_r[smsc_pkg::BIT_DAC_EN0]};
            extClkSelect_r <= stabTime_r[smsc_pkg::BIT_EXT_CLK];
            resumeInline_r <= abortStop || nmiPendSet || pinPendSet;
            ackNmi_r       <= (inWake && wakeByNmi_r && nmiAckOk) || nmiPendAck;
            ackPin_r       <= (inWake && !wakeByNmi_r && pinAckOk) || pinPendAck;
        end
    end

    // =====================================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    sequence s_stopRequested;
        ce && stopArmed && !haltReleaseCond && !nmiPend_r && !pinPend_r;
    endsequence
    sequence s_inStop;
        state_r == smsc_pkg::ST_STOP;
    endsequence

    a_stop_entry_taken: assert property (s_stopRequested |=> s_inStop)
        else $error("stop request did not enter stop");
    a_standby_write_path: assert property ($changed(standbyCtrl_r) && !$past(stopArmed)
                                            |-> $past(wrStandby))
        else $error("standby control changed without dedicated write");
    a_release_aborts_stop: assert property (ce && stopArmed && haltReleaseCond
                                            |=> state_r == smsc_pkg::ST_RUN && resumeInline_r)
        else $error("stop entered despite release condition");
    a_stop_clocks_off: assert property (s_inStop ##1 s_inStop
                                        |-> !pinCtl_r.oscEnable && !pinCtl_r.sysClkEnable
                                            && !pinCtl_r.cpuRun && !pinCtl_r.adcClkRun)
        else $error("clocks running in stop");
    a_stop_bus_float: assert property (s_inStop ##1 s_inStop
                                       |-> !pinCtl_r.busPinOe && pinCtl_r.holdAckForceLow
                                           && pinCtl_r.ioHold && !pinCtl_r.holdReqInEn)
        else $error("bus pins not floated in stop");
    a_masked_pin_holds: assert property (ce && (state_r == smsc_pkg::ST_STOP) && !nmiEdge && !pinWake
                                         |=> s_inStop)
        else $error("stop released without valid wake source");
    a_stab_min_wait: assert property (ce && timerStart |=> (state_r == smsc_pkg::ST_STAB)[*4])
        else $error("stabilization time cut short");
    a_nmi_blocked_pends: assert property (ce && inWake && wakeByNmi_r && nmiBlockSvc
                                          |=> resumeInline_r && nmiPend_r && !ackNmi_r)
        else $error("blocked nmi wake not held pending");
    a_pin_wake_ack: assert property (ce && inWake && !wakeByNmi_r && pinAckOk
                                     |=> ackPin_r && !resumeInline_r)
        else $error("enabled pin wake not acknowledged");
    a_pending_acked: assert property (ce && state_r == smsc_pkg::ST_RUN && nmiPend_r && !nmiBlockSvc
                                      |=> ackNmi_r && !nmiPend_r)
        else $error("pending nmi not acknowledged when possible");

endmodule
`default_nettype wire

// file: testbench/smsc_pin_model.sv
// Purpose: far-side model: cpu retire pulse and the three wake pins
// Assumes: fire bits are one-cycle requests from the bench
// Notes:   pins idle low, so with rising edges selected an idle pin never wakes
`timescale 1ns/1ps
`default_nettype none
module smsc_pin_model
(
    input  wire logic       clk,
    input  wire logic       rstn,
    input  wire logic       regWr,
    input  wire logic       wrDedicated,
    input  wire logic [2:0] fire,
    output logic            instrDone,
    output logic [2:0]      pins
);
    logic [2:0] cnt_r;
    // =====================================================================
    // retire follows the dedicated store; a pin stays high a few cycles
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            instrDone <= 1'b0;
            pins      <= 3'h0;
            cnt_r     <= 3'h0;
        end
        else
        begin
            instrDone <= regWr & wrDedicated;
            if (|fire)
            begin
                pins  <= fire;
                cnt_r <= 3'h4;
            end
            else if (cnt_r != 3'h0)
                cnt_r <= cnt_r - 3'h1;
            else
                pins <= 3'h0;
        end
    end
endmodule
`default_nettype wire

// file: testbench/smsc_standby_ctrl_bench.sv
// Purpose: self-checking bench for the stop-mode standby controller
// Assumes: 250 MHz clock, async active-low reset held 10 cycles
// Notes:   read data are checked from a queue by a separate monitor
`timescale 1ns/1ps
`default_nettype none
module smsc_standby_ctrl_bench;
    logic                      clk, rstn, regWr, regRd, wrDedicated, instrDone;
    logic                      haltReleaseCond, globalIrqEnable, nmiBlockSvc, maskSvcActive;
    logic                      adcConvOn_r, extClkSelect_r, resumeInline_r, ackNmi_r, ackPin_r;
    logic                      rdTaken = 1'b0;
    logic [1:0]                dacAnalogOe_r, maskSvcLevel, pinIrqLevel;
    logic [2:0]                regAddr, fire, pins;
    logic [7:0]                regWdata, regRdata, d;
    logic [7:0]                expQ[$];
    logic [7:0]                rstVals [4] = '{smsc_pkg::RST_STANDBY_CTRL, smsc_pkg::RST_STAB_TIME,
                                               smsc_pkg::RST_IRQ_CFG, smsc_pkg::RST_ANALOG_CTRL};
    smsc_pkg::smsc_pinctl_type pinCtl_r;
    int                        fails, checked, n, seed;

    smsc_standby_ctrl i_smsc_standby_ctrl (.clk(clk), .rstn(rstn), .ce(1'b1), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .wrDedicated(wrDedicated),
        .instrDone(instrDone), .haltReleaseCond(haltReleaseCond), .nmiPin(pins[0]),
        .extIrqPinA(pins[1]), .extIrqPinB(pins[2]), .edgeRising(3'h7),
        .globalIrqEnable(globalIrqEnable), .nmiBlockSvc(nmiBlockSvc), .maskSvcActive(maskSvcActive),
        .maskSvcLevel(maskSvcLevel), .pinIrqLevel(pinIrqLevel), .regRdata(regRdata), .pinCtl_r(pinCtl_r),
        .adcConvOn_r(adcConvOn_r), .dacAnalogOe_r(dacAnalogOe_r), .extClkSelect_r(extClkSelect_r),
        .resumeInline_r(resumeInline_r), .ackNmi_r(ackNmi_r), .ackPin_r(ackPin_r));
    smsc_pin_model i_smsc_pin_model (.clk(clk), .rstn(rstn), .regWr(regWr),
        .wrDedicated(wrDedicated), .fire(fire), .instrDone(instrDone), .pins(pins));

    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s exp=%h seen=%h", nm, exp, seen);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d fails=%0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wr(input logic [2:0] a, input logic [7:0] v, input logic ded);
        @(posedge clk);
        regAddr     <= a;
        regWdata    <= v;
        regWr       <= 1'b1;
        wrDedicated <= ded;
        @(posedge clk);
        regWr       <= 1'b0;
        wrDedicated <= 1'b0;
    endtask
    task automatic rd(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk);
        regAddr <= a;
        regRd   <= 1'b1;
        expQ.push_back(v);
        @(posedge clk);
        regRd   <= 1'b0;
    endtask
    // bounded wait for any acknowledge or inline-resume pulse
    task automatic waitEv();
        n = 0;
        do
        begin
            @(negedge clk);
            n++;
        end
        while (!(ackNmi_r | ackPin_r | resumeInline_r) && n < 3000);
    endtask
    task automatic stopReq();
        wr(3'h0, 8'h01, 1'b1);
        repeat (4) @(posedge clk); // room for the four no-op slots
        check("pinCtlStop", pinCtl_r, smsc_pkg::PINCTL_STOP);
    endtask
    task automatic firePin(input logic [2:0] f);
        @(posedge clk);
        fire <= f;
        @(posedge clk);
        fire <= 3'h0;
    endtask

    // =====================================================================
    // clock, read-data monitor and watchdog
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk)
        rdTaken <= regRd;
    always @(negedge clk)
        if (rdTaken === 1'b1)
            check("regRdata", regRdata, expQ.pop_front());
    initial
    begin
        repeat (30000) @(posedge clk);
        fails++;
        summarize();
    end

    // =====================================================================
    // main sequence
    initial
    begin
        seed = 32'hf7e7;
        {regWr, regRd, wrDedicated, haltReleaseCond, nmiBlockSvc} = 5'h00;
        globalIrqEnable = 1'b1;
        maskSvcActive = 1'b0;
        {maskSvcLevel, pinIrqLevel} = 4'hc;
        {regAddr, fire, regWdata} = 14'h0000;
        fails = 0;
        checked = 0;
        rstn = 1'b0;
        repeat (10) @(posedge clk);
        rstn <= 1'b1;
        for (int i = 0; i < 6; i++)
            rd(3'(i), i < 4 ? rstVals[i] : 8'h00);
        wr(3'h0, 8'h01, 1'b0);
        rd(3'h0, 8'h00);
        for (int i = 0; i < 4; i++)
        begin
            d = 8'($random(seed)) & 8'h07;
            wr(3'h3, d, 1'b0);
            rd(3'h3, d);
            check("analogOut", {5'h0, dacAnalogOe_r, adcConvOn_r}, d);
        end
        wr(3'h3, 8'h00, 1'b0); // converter off, both d/a channels off before stop
        wr(3'h1, 8'h80, 1'b0);
        repeat (2) @(posedge clk);
        check("extClk", 8'(extClkSelect_r), 8'h01);
        haltReleaseCond <= 1'b1;
        wr(3'h0, 8'h01, 1'b1);
        waitEv();
        check("abortResume", 8'(resumeInline_r), 8'h01);
        check("abortPins", pinCtl_r, smsc_pkg::PINCTL_RUN);
        haltReleaseCond <= 1'b0; // pending request cleared before the real stop
        rd(3'h0, 8'h00);
        stopReq();
        firePin(3'b010);
        repeat (40) @(posedge clk);
        rd(3'h4, 8'h01);
        wr(3'h2, 8'h00, 1'b0);
        firePin(3'b010);
        repeat (3) @(posedge clk);
        check("pinCtlStab", pinCtl_r, smsc_pkg::PINCTL_STAB);
        waitEv();
        check("ackPin", 8'(ackPin_r), 8'h01);
        check("stabLong", 8'(n >= smsc_pkg::STAB_BASE_CYC), 8'h01);
        nmiBlockSvc <= 1'b1;
        stopReq();
        firePin(3'b001);
        waitEv();
        check("nmiInline", 8'(resumeInline_r), 8'h01);
        nmiBlockSvc <= 1'b0;
        waitEv();
        check("nmiLateAck", 8'(ackNmi_r), 8'h01);
        globalIrqEnable <= 1'b0;
        stopReq();
        firePin(3'b100);
        waitEv();
        check("pinInline", 8'(resumeInline_r), 8'h01);
        globalIrqEnable <= 1'b1;
        waitEv();
        check("pinLateAck", 8'(ackPin_r), 8'h01);
        maskSvcActive <= 1'b1;
        pinIrqLevel   <= 2'h3;
        stopReq();
        firePin(3'b010);
        waitEv();
        check("lvl3Ack", 8'(ackPin_r), 8'h01);
        wr(3'h2, 8'h10, 1'b0);
        stopReq();
        firePin(3'b010);
        waitEv();
        check("samePrioInline", 8'(resumeInline_r), 8'h01);
        maskSvcActive <= 1'b0;
        waitEv();
        check("samePrioLateAck", 8'(ackPin_r), 8'h01);
        stopReq();
        rstn <= 1'b0;
        repeat (2) @(posedge clk);
        check("resetPins", pinCtl_r, smsc_pkg::PINCTL_RUN);
        rstn <= 1'b1;
        rd(3'h4, 8'h00);
        summarize();
    end
endmodule
`default_nettype wire
